// file: dv/ebd_timebase_checker.sv
// Checker for bus answers, divisor lock and tick of the timebase divider
module ebd_timebase_checker
  import ebd_pkg::*;
#(
  parameter bit DIV_WRITES_FROZEN = 1'b0  // Same as design
)
(
  input wire logic              clk,                     // Clock
  input wire logic              rst,                     // Reset
  input wire logic              ce,                      // Clock enable
  input wire logic              nvm_init,                // Shadow fill
  input wire logic              crystal_reference_clock, // Crystal strobe
  input wire logic              stop_mode,               // Stop mode
  input wire logic [ADDR_W-1:0] avs_address,             // Address
  input wire logic              avs_read,                // Read
  input wire logic              avs_write,               // Write
  input wire logic [3:0]        avs_byteenable,          // Lanes
  input wire logic [31:0]       avs_writedata,           // Write data
  input wire logic [31:0]       avs_readdata,            // Read data
  input wire logic              avs_waitrequest,         // Stall
  input wire logic              timebase_tick,           // Tick
  input wire logic [DIV_W-1:0]  timebase_divisor,        // Divisor
  input wire logic              divisor_locked           // Lock on
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic req;
  logic div_wr;
  assign req = avs_read | avs_write;
  assign div_wr = avs_write & ~avs_waitrequest
                & (avs_address == OFS_DIV_HIGH || avs_address == OFS_DIV_LOW);

  chk_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  chk_wait_single: assert property (req && !avs_waitrequest |=> avs_waitrequest || !req)
    else $error("waitrequest low twice for one access");
  chk_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  chk_lock_cause: assert property ($changed(divisor_locked) && !$past(rst)
      |-> $past(avs_write && !avs_waitrequest && avs_address == OFS_DIV_HIGH))
    else $error("lock changed without high divisor write");
  chk_lock_sticky: assert property (divisor_locked |=> divisor_locked)
    else $error("lock released without reset");
  chk_div_frozen: assert property (divisor_locked |=> $stable(timebase_divisor))
    else $error("divisor changed while locked");
  chk_div_cause: assert property ($changed(timebase_divisor) && !$past(rst) |-> $past(div_wr))
    else $error("divisor changed without divisor write");
  chk_tick_pulse: assert property (timebase_tick && timebase_divisor > 11'h001 |=> !timebase_tick)
    else $error("tick longer than one cycle");
endmodule

bind ebd_timebase ebd_timebase_checker #(.DIV_WRITES_FROZEN(DIV_WRITES_FROZEN)) u_chk (
  .clk(clk), .rst(rst), .ce(ce), .nvm_init(nvm_init),
  .crystal_reference_clock(crystal_reference_clock), .stop_mode(stop_mode),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timebase_tick(timebase_tick), .timebase_divisor(timebase_divisor),
  .divisor_locked(divisor_locked));

// file: dv/ebd_timebase_tb.sv
// Self-checking bench for the timebase divider top
module ebd_timebase_tb;
  import ebd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int XDIV    = 128;
  localparam int EXP_DIV = $rtoi(200.0e6 / XDIV * 35.0e-6 + 0.5);

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              nvm_init = 1'b1;
  logic              ce = 1'b1;
  logic              stop_mode = 1'b0;
  logic              crystal_reference_clock = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              timebase_tick;
  logic [DIV_W-1:0]  timebase_divisor;
  logic              divisor_locked;
  logic [7:0]        q;
  int                xcnt = 0;
  int                ntick = 0;
  int                errors = 0;
  int                compares = 0;

  always #2.5 clk = ~clk;

  // Crystal strobe, one cycle in every XDIV
  always @(posedge clk) begin
    xcnt <= (xcnt == XDIV - 1) ? 0 : xcnt + 1;
    crystal_reference_clock <= (xcnt == XDIV - 1);
  end

  // Running count of timebase ticks
  always @(posedge clk) begin
    if (timebase_tick === 1'b1) begin
      ntick <= ntick + 1;
    end
  end

  ebd_timebase dut (
    .clk(clk), .rst(rst), .ce(ce), .nvm_init(nvm_init),
    .crystal_reference_clock(crystal_reference_clock), .stop_mode(stop_mode),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timebase_tick(timebase_tick), .timebase_divisor(timebase_divisor),
    .divisor_locked(divisor_locked));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic gap(input int exp);
    int n;
    n = 0;
    do @(posedge clk); while (timebase_tick !== 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (timebase_tick !== 1'b1);
    chk("tick gap", exp, n);
  endtask

  task automatic wait_idle();
    do bus(0, OFS_STATUS, 8'h00); while (q[1:0] !== 2'b00);
  endtask

  task automatic chk_span(input string what, input int lo, input int got);
    compares++;
    if (got <= lo || got > lo + 8) begin
      errors++;
      $display("BAD %s expected %0d+ seen %0d", what, lo + 1, got);
    end
  endtask

  // Starts a low shadow operation, times it in ticks, then checks discharge
  task automatic op_time(input logic [4:0] a, input logic [7:0] d, input logic [7:0] exp);
    int t0;
    bus(1, a, d);
    t0 = ntick;
    do bus(0, OFS_SHADOW_LOW, 8'h00); while (q !== exp);
    chk_span("shadow op ticks", PGM_TICKS, ntick - t0);
    bus(0, OFS_STATUS, 8'h00);
    chk("discharge busy", 32'h1, q[0]);
    wait_idle();
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("divisor", 32'h7ff, timebase_divisor);
    chk("locked", 32'h0, divisor_locked);
    bus(0, OFS_DIV_LOW, 8'h00);
    chk("low", 32'hff, q);
    bus(0, OFS_DIV_HIGH, 8'h00);
    chk("high", 32'h87, q & 8'h87);
    bus(1, 5'h1c, 8'h5a);
    bus(0, 5'h1c, 8'h00);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask

  task automatic t_crystal();
    bus(1, OFS_CONTROL, 8'h04);
    bus(1, OFS_DIV_LOW, EXP_DIV[7:0]);
    bus(1, OFS_DIV_HIGH, 8'h80);
    chk("divisor", EXP_DIV, timebase_divisor);
    gap(EXP_DIV * XDIV);
    bus(1, OFS_DIV_HIGH, 8'h81);
    chk("divisor", 32'h100 + EXP_DIV, timebase_divisor);
    $display("test crystal done");
  endtask

  task automatic t_bus();
    bus(1, OFS_CONTROL, 8'h05);
    bus(1, OFS_DIV_HIGH, 8'h80);
    bus(1, OFS_DIV_LOW, 8'h02);
    gap(2);
    bus(1, OFS_CONTROL, 8'h07);
    bus(1, OFS_DIV_LOW, 8'h09);
    chk("latched divisor", 32'h2, timebase_divisor);
    bus(1, OFS_CONTROL, 8'h05);
    $display("test bus clock done");
  endtask

  task automatic t_shadow();
    wait_idle();
    bus(1, OFS_SHADOW_LOW, 8'h03);
    wait_idle();
    bus(1, OFS_SHADOW_HIGH, 8'h00);
    wait_idle();
    bus(0, OFS_SHADOW_LOW, 8'h00);
    chk("shadow low", 32'h3, q);
    chk("divisor", 32'h2, timebase_divisor);
    $display("test shadow done");
  endtask

  task automatic t_lock();
    bus(1, OFS_DIV_HIGH, 8'h02);
    chk("divisor", 32'h202, timebase_divisor);
    chk("locked", 32'h1, divisor_locked);
    bus(1, OFS_DIV_LOW, 8'h09);
    bus(1, OFS_DIV_HIGH, 8'h80);
    chk("divisor", 32'h202, timebase_divisor);
    bus(1, OFS_SHADOW_LOW, 8'h07);
    bus(1, OFS_ERASE, 8'h03);
    bus(0, OFS_STATUS, 8'h00);
    chk("busy", 32'h0, q[0]);
    bus(0, OFS_SHADOW_LOW, 8'h00);
    chk("shadow low", 32'h3, q);
    do_reset();
    chk("divisor", 32'h3, timebase_divisor);
    chk("locked", 32'h1, divisor_locked);
    gap(3 * XDIV);
    bus(1, OFS_DIV_HIGH, 8'h80);
    chk("locked", 32'h1, divisor_locked);
    $display("test lock done");
  endtask

  task automatic t_enable();
    int n;
    n = 0;
    do @(posedge clk); while (timebase_tick !== 1'b1);
    ce <= 1'b0;
    repeat (10) begin
      @(posedge clk);
      if (timebase_tick !== 1'b0) begin
        n++;
      end
    end
    chk("frozen ticks", 32'h0, n);
    ce <= 1'b1;
    gap(2);
    $display("test enable done");
  endtask

  task automatic t_nvm();
    wait_idle();
    op_time(OFS_SHADOW_LOW, 8'h55, 8'h55);
    op_time(OFS_ERASE, 8'h01, 8'hff);
    $display("test timing done");
  endtask

  task automatic t_recover();
    int t0;
    bus(1, OFS_CONTROL, 8'h01);
    bus(1, OFS_CONTROL, 8'h05);
    t0 = ntick;
    bus(0, OFS_STATUS, 8'h00);
    chk("recovering", 32'h1, q[1]);
    do bus(0, OFS_STATUS, 8'h00); while (q[1] !== 1'b0);
    chk_span("enable recovery ticks", RECOVER_TICKS, ntick - t0);
    stop_mode <= 1'b1;
    @(posedge clk);
    stop_mode <= 1'b0;
    @(posedge clk);
    t0 = ntick;
    bus(0, OFS_STATUS, 8'h00);
    chk("stop recovering", 32'h1, q[1]);
    do bus(0, OFS_STATUS, 8'h00); while (q[1] !== 1'b0);
    chk_span("stop recovery ticks", RECOVER_TICKS, ntick - t0);
    $display("test recovery done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    nvm_init <= 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_crystal();
    t_bus();
    t_enable();
    t_nvm();
    t_recover();
    t_shadow();
    t_lock();
    summarize();
  end

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("BAD watchdog expected finish seen timeout");
    summarize();
  end
endmodule

// file: rtl/ebd_divider.sv
// Counter that divides the selected reference into the timebase tick
module ebd_divider
  import ebd_pkg::*;
(
  input  wire logic             clk,       // System clock
  input  wire logic             rst,       // Synchronous reset, active high
  input  wire logic             ce,        // Clock enable
  input  wire logic             ref_en,    // One reference clock period elapsed
  input  wire logic [DIV_W-1:0] divisor,   // Programmed divisor
  output logic                  tick       // One-cycle timebase pulse
);

  logic [DIV_W-1:0] count_q;
  logic [DIV_W-1:0] count_d;
  logic             tick_d;
  wire  logic       div_zero = (divisor == '0);
  wire  logic       at_end   = ((count_q + 1'b1) >= divisor);

  always_comb begin
    count_d = count_q;
    tick_d  = 1'b0;
    if (ref_en && !div_zero) begin
      if (at_end) begin
        count_d = '0;
        tick_d  = 1'b1;
      end else begin
        count_d = count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
      tick    <= 1'b0;
    end else if (ce) begin
      count_q <= count_d;
      tick    <= tick_d;
    end
  end

endmodule

// file: rtl/ebd_pkg.sv
// Constants, register map and types shared by the timebase divider design
//
// Contract
// - Deliver steady 35 us timebase tick
// - Reference is crystal clock or bus clock
// - Divisor is 11 bits, high and low
// - Reset copies shadow registers into divisor
// - Lock-disable bit: 1 off, 0 on
// - Locked: divisor writes ignored, bit included
// - Locked: shadow program/erase blocked
// - Divisor readable always, writable unlatched, unlocked
// - Present silicon: divisor writes have no effect
// - Byte program lasts at least 10 ms
// - Any erase lasts at least 10 ms
// - 100 us discharge after program/erase
// - 600 us recovery after enable, stop
// - Shadow changes reach divisor at reset only
// - Shadow lock bit 0 locks permanently
package ebd_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DIV_W  = 11;
  localparam int unsigned CNT_W  = 9;

  // Register byte addresses
  localparam logic [4:0] OFS_DIV_HIGH    = 5'h00;
  localparam logic [4:0] OFS_DIV_LOW     = 5'h04;
  localparam logic [4:0] OFS_SHADOW_HIGH = 5'h08;
  localparam logic [4:0] OFS_SHADOW_LOW  = 5'h0c;
  localparam logic [4:0] OFS_CONTROL     = 5'h10;
  localparam logic [4:0] OFS_ERASE       = 5'h14;
  localparam logic [4:0] OFS_STATUS      = 5'h18;

  // Field positions
  localparam int unsigned HIGH_LOCK_DIS_BIT = 7;
  localparam int unsigned CTL_CLK_SEL_BIT   = 0;
  localparam int unsigned CTL_LATCH_BIT     = 1;
  localparam int unsigned CTL_EE_EN_BIT     = 2;
  localparam int unsigned ERASE_LOW_BIT     = 0;
  localparam int unsigned ERASE_HIGH_BIT    = 1;
  localparam int unsigned STS_BUSY_BIT      = 0;
  localparam int unsigned STS_RECOV_BIT     = 1;
  localparam int unsigned STS_LOCK_BIT      = 2;

  // Reset and erased values
  localparam logic [7:0] NVM_ERASED    = 8'hff;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic       CLK_SEL_RESET = 1'b0;
  localparam logic       LATCH_RESET   = 1'b0;
  localparam logic       EE_EN_RESET   = 1'b1;

  // Times, counted in timebase ticks of TB_PERIOD_US
  localparam int unsigned TB_PERIOD_US  = 35;
  localparam int unsigned T_PGM_US      = 10000;
  localparam int unsigned T_DISCHG_US   = 100;
  localparam int unsigned T_RECOVER_US  = 600;
  localparam logic [CNT_W-1:0] PGM_TICKS =
    CNT_W'((T_PGM_US + TB_PERIOD_US - 1) / TB_PERIOD_US);
  localparam logic [CNT_W-1:0] DISCHG_TICKS =
    CNT_W'((T_DISCHG_US + TB_PERIOD_US - 1) / TB_PERIOD_US);
  localparam logic [CNT_W-1:0] RECOVER_TICKS =
    CNT_W'((T_RECOVER_US + TB_PERIOD_US - 1) / TB_PERIOD_US);

  typedef enum logic [1:0] {
    NVM_IDLE,
    NVM_PROGRAM,
    NVM_DISCHARGE,
    NVM_RECOVER
  } ebd_nvm_state_t;

endpackage

// file: rtl/ebd_shadow.sv
// Non-volatile shadow bytes with program/erase, discharge and recovery timing
module ebd_shadow
  import ebd_pkg::*;
(
  input  wire logic       clk,           // System clock
  input  wire logic       rst,           // Synchronous reset, active high
  input  wire logic       ce,            // Clock enable
  input  wire logic       nvm_init,      // Power-on fill to erased value
  input  wire logic       tick,          // Timebase tick
  input  wire logic       op_start,      // Start program or erase
  input  wire logic       op_sel_high,   // 1: high shadow, 0: low shadow
  input  wire logic       op_erase,      // 1: erase, 0: program
  input  wire logic [7:0] op_data,       // Byte to program
  input  wire logic       recover_start, // Enable or stop exit seen
  output logic      [7:0] shadow_low,    // Low shadow byte
  output logic      [7:0] shadow_high,   // High shadow byte
  output logic            busy,          // Program, erase or discharge running
  output logic            recovering     // Recovery time running
);

  logic [7:0]     mem_q [2];
  ebd_nvm_state_t state_q;
  ebd_nvm_state_t state_d;
  logic [CNT_W-1:0] ticks_q;
  logic [CNT_W-1:0] ticks_d;
  logic           sel_q;
  logic           erase_q;
  logic [7:0]     data_q;
  logic           commit;

  assign shadow_low  = mem_q[0];
  assign shadow_high = mem_q[1];
  assign busy        = (state_q == NVM_PROGRAM) || (state_q == NVM_DISCHARGE);
  assign recovering  = (state_q == NVM_RECOVER);

  // One tick beyond the limit: the first period after the start is only partial
  wire logic done = tick && (ticks_q >= (state_q == NVM_PROGRAM ? PGM_TICKS :
                    state_q == NVM_DISCHARGE ? DISCHG_TICKS : RECOVER_TICKS));

  always_comb begin
    state_d = state_q;
    ticks_d = tick ? ticks_q + 1'b1 : ticks_q;
    commit  = 1'b0;
    if (recover_start) begin
      state_d = NVM_RECOVER;
      ticks_d = '0;
    end else begin
      unique case (state_q)
        NVM_IDLE: begin
          ticks_d = '0;
          if (op_start) begin
            state_d = NVM_PROGRAM;
          end
        end
        NVM_PROGRAM: begin
          if (done) begin
            state_d = NVM_DISCHARGE;
            ticks_d = '0;
            commit  = 1'b1;
          end
        end
        NVM_DISCHARGE: begin
          if (done) begin
            state_d = NVM_IDLE;
          end
        end
        NVM_RECOVER: begin
          if (done) begin
            state_d = NVM_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= NVM_IDLE;
      ticks_q <= '0;
      sel_q   <= 1'b0;
      erase_q <= 1'b0;
      data_q  <= BYTE_ZERO;
    end else if (ce) begin
      state_q <= state_d;
      ticks_q <= ticks_d;
      if (state_q == NVM_IDLE && op_start && !recover_start) begin
        sel_q   <= op_sel_high;
        erase_q <= op_erase;
        data_q  <= op_data;
      end
    end
  end

  // Shadow bytes ignore system reset: only power-on fill and program/erase commits touch them
  always_ff @(posedge clk) begin
    if (nvm_init) begin
      mem_q[0] <= NVM_ERASED;
      mem_q[1] <= NVM_ERASED;
    end else if (ce && commit) begin
      mem_q[sel_q] <= erase_q ? NVM_ERASED : data_q;
    end
  end

endmodule

// file: rtl/ebd_timebase.sv
// Top of the timebase divider: register slave, divisor lock and timebase
module ebd_timebase
  import ebd_pkg::*;
#(
  parameter bit DIV_WRITES_FROZEN = 1'b0  // 1 models silicon without live registers
)
(
  input  wire logic              clk,                     // System (bus) clock
  input  wire logic              rst,                     // Synchronous reset, active high
  input  wire logic              ce,                      // Clock enable, freezes state
  input  wire logic              nvm_init,                // Power-on fill of shadow bytes
  input  wire logic              crystal_reference_clock, // Crystal period strobe
  input  wire logic              stop_mode,               // Device in stop mode
  input  wire logic [ADDR_W-1:0] avs_address,             // Byte address
  input  wire logic              avs_read,                // Read request
  input  wire logic              avs_write,               // Write request
  input  wire logic [3:0]        avs_byteenable,          // Byte lanes
  input  wire logic [31:0]       avs_writedata,           // Write data
  output logic      [31:0]       avs_readdata,            // Read data
  output logic                   avs_waitrequest,         // Stall
  output logic                   timebase_tick,           // 35 us tick pulse
  output logic      [DIV_W-1:0]  timebase_divisor,        // Active divisor
  output logic                   divisor_locked           // Lock is on
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [31:0] widen(input logic [7:0] b);
    widen = {24'h0000_00, b};
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic       lock_dis_q;
  logic [2:0] div_hi_q;
  logic [7:0] div_lo_q;
  logic       clk_sel_q;
  logic       latch_q;
  logic       ee_en_q;
  logic       stop_q;
  logic       ack_q;
  logic [31:0] rdata_q;

  logic [7:0] shadow_low;
  logic [7:0] shadow_high;
  logic       nvm_busy;
  logic       nvm_recovering;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire logic req     = avs_read | avs_write;
  wire logic do_wr   = ce & avs_write & ack_q;
  wire logic lane0   = avs_byteenable[0];
  wire logic [7:0] wbyte = avs_writedata[7:0];

  wire logic wr_hi   = do_wr & lane0 & hit(avs_address, OFS_DIV_HIGH);
  wire logic wr_lo   = do_wr & lane0 & hit(avs_address, OFS_DIV_LOW);
  wire logic wr_shh  = do_wr & lane0 & hit(avs_address, OFS_SHADOW_HIGH);
  wire logic wr_shl  = do_wr & lane0 & hit(avs_address, OFS_SHADOW_LOW);
  wire logic wr_ctl  = do_wr & lane0 & hit(avs_address, OFS_CONTROL);
  wire logic wr_ers  = do_wr & lane0 & hit(avs_address, OFS_ERASE);

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Divisor lock and write permission

  assign divisor_locked = ~lock_dis_q;
  wire logic div_wr_ok  = ~latch_q & lock_dis_q & ~DIV_WRITES_FROZEN;

  // Shadow operations refused while locked, busy or recovering
  wire logic nvm_free   = lock_dis_q & ~nvm_busy & ~nvm_recovering;
  wire logic ers_hi     = wbyte[ERASE_HIGH_BIT];
  wire logic ers_lo     = wbyte[ERASE_LOW_BIT];
  wire logic op_start   = nvm_free & (wr_shh | wr_shl | (wr_ers & (ers_hi | ers_lo)));
  wire logic op_sel_hi  = wr_shh | (wr_ers & ers_hi);
  wire logic op_erase   = wr_ers;

  //////////////////////////////////////////////////////////////////////////////
  // Recovery triggers

  wire logic ee_en_new  = wr_ctl ? wbyte[CTL_EE_EN_BIT] : ee_en_q;
  wire logic ee_rise    = ee_en_new & ~ee_en_q;
  wire logic stop_exit  = stop_q & ~stop_mode;
  wire logic recover_go = ce & (ee_rise | stop_exit);

  //////////////////////////////////////////////////////////////////////////////
  // Reference selection and divisor

  assign timebase_divisor = {div_hi_q, div_lo_q};
  wire logic ref_en = clk_sel_q ? 1'b1 : crystal_reference_clock;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (1'b1)
      hit(avs_address, OFS_DIV_HIGH): begin
        rmux = widen({lock_dis_q, 4'h0, div_hi_q});
      end
      hit(avs_address, OFS_DIV_LOW): begin
        rmux = widen(div_lo_q);
      end
      hit(avs_address, OFS_SHADOW_HIGH): begin
        rmux = widen(shadow_high);
      end
      hit(avs_address, OFS_SHADOW_LOW): begin
        rmux = widen(shadow_low);
      end
      hit(avs_address, OFS_CONTROL): begin
        rmux = widen({5'h00, ee_en_q, latch_q, clk_sel_q});
      end
      hit(avs_address, OFS_STATUS): begin
        rmux = widen({5'h00, divisor_locked, nvm_recovering, nvm_busy});
      end
      default: begin
        rmux = 32'h0000_0000;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdata_q <= rmux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Divisor registers, reloaded from the shadow bytes on reset

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_dis_q <= shadow_high[HIGH_LOCK_DIS_BIT];
      div_hi_q   <= shadow_high[2:0];
      div_lo_q   <= shadow_low;
    end else if (ce && div_wr_ok) begin
      if (wr_hi) begin
        lock_dis_q <= wbyte[HIGH_LOCK_DIS_BIT];
        div_hi_q   <= wbyte[2:0];
      end
      if (wr_lo) begin
        div_lo_q <= wbyte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register and stop tracking

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_sel_q <= CLK_SEL_RESET;
      latch_q   <= LATCH_RESET;
      ee_en_q   <= EE_EN_RESET;
      stop_q    <= 1'b0;
    end else if (ce) begin
      stop_q <= stop_mode;
      if (wr_ctl) begin
        clk_sel_q <= wbyte[CTL_CLK_SEL_BIT];
        latch_q   <= wbyte[CTL_LATCH_BIT];
        ee_en_q   <= wbyte[CTL_EE_EN_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Submodules

  ebd_divider u_divider (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .ref_en  (ref_en),
    .divisor (timebase_divisor),
    .tick    (timebase_tick)
  );

  ebd_shadow u_shadow (
    .clk           (clk),
    .rst           (rst),
    .ce            (ce),
    .nvm_init      (nvm_init),
    .tick          (timebase_tick),
    .op_start      (op_start),
    .op_sel_high   (op_sel_hi),
    .op_erase      (op_erase),
    .op_data       (wbyte),
    .recover_start (recover_go),
    .shadow_low    (shadow_low),
    .shadow_high   (shadow_high),
    .busy          (nvm_busy),
    .recovering    (nvm_recovering)
  );

endmodule
